// *** camera_input_pkg.sv ***
/*
 * Constants, register layout and carrier types for the camera input
 * configuration block. Assumes a 50 MHz system clock and a classic
 * Wishbone slave with 32-bit data; register byte address = index * 4.
 */
// Function
// [RULE_01] port B edge select: 0 rising, 1 falling
// [RULE_02] edge select changed only while disabled
// [RULE_03] software never writes reserved 2008h-200Eh
// [RULE_04] chroma bit: 0 straight, 1 offset binary
// [RULE_05] software sets chroma bit to camera format
// [RULE_06] embedded sync off: separate sync lines used
// [RULE_07] embedded sync on: timing from BT656 codes
// [RULE_08] port select 000 first, 001 second, else reserved
// [RULE_09] software writes 00b to bits 11-10
// [RULE_10] reserved bits 15-12 and 9 reset zero
// [RULE_11] port B reference polarity, locked while enabled
// [RULE_12] enable cleared stops clock, output driven low
// [RULE_13] clock output port field decode
package camera_input_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [13:0] IDX_CAM2_SIGNAL = 14'h2006;
    localparam logic [13:0] IDX_RSVD_FIRST = 14'h2008;
    localparam logic [13:0] IDX_RSVD_LAST = 14'h200E;
    localparam logic [13:0] IDX_CAM_CONFIG = 14'h2010;
    localparam logic [13:0] IDX_CAM_STATUS = 14'h2030;

    // ------------------------------------------------------------
    // reset values and field codes
    // ------------------------------------------------------------
    localparam logic [5:0] CAM2_SIGNAL_RESET = 6'h00;
    localparam logic [8:0] CAM_CONFIG_RESET = 9'h000;
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] CLKP_FOLLOW = 3'h0;
    localparam logic [2:0] CLKP_A = 3'h1;
    localparam logic [2:0] CLKP_B = 3'h2;
    localparam logic [2:0] CLKP_BOTH = 3'h3;
    localparam logic [2:0] CLKP_NONE = 3'h4;
    localparam logic [7:0] CHROMA_FLIP = 8'h80;
    localparam logic [7:0] SYNC_BYTE_FF = 8'hFF;
    localparam logic [7:0] SYNC_BYTE_00 = 8'h00;
    localparam int BT_F_BIT = 6;
    localparam int BT_V_BIT = 5;
    localparam int BT_H_BIT = 4;

    // camera clock output half period in system cycles
    localparam int CAM_CLK_HALF = 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic clk_mode;
        logic [1:0] byte_order;
        logic href_high;
        logic vref_high;
        logic clk_falling;
    } cam2_signal_s;

    typedef struct packed {
        logic signed_chroma;
        logic bt656;
        logic [2:0] port;
        logic [2:0] clk_port;
        logic enable;
    } cam_config_s;

    typedef struct packed {
        logic frame_valid;
        logic line_valid;
        logic valid;
        logic [7:0] data;
    } pixel_s;

    typedef enum logic [1:0] {
        SYNC_IDLE = 2'b00,
        SYNC_FF = 2'b01,
        SYNC_Z1 = 2'b10,
        SYNC_Z2 = 2'b11
    } sync_state_e;

endpackage

// *** camera_input_config.sv ***
/*
 * Camera input configuration and pixel capture for two parallel camera
 * ports. Assumes camera pins are asynchronous to clk_sys and that the
 * pixel clock is at most a quarter of the system clock rate.
 */
// The Wishbone slave port is this design's own decision.
module camera_input_config
    import camera_input_pkg::*;
#(
    parameter int CLK_HALF = CAM_CLK_HALF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic cam_a_pixel_clock_in,
    input wire logic cam_a_line_reference,
    input wire logic cam_a_frame_reference,
    input wire logic [7:0] cam_a_data,
    input wire logic cam_b_pixel_clock_in,
    input wire logic cam_b_line_reference,
    input wire logic cam_b_frame_reference,
    input wire logic [7:0] cam_b_data,
    output logic camera_clock_output_a,
    output logic camera_clock_output_b,
    output pixel_s pixel_out
);

    // ------------------------------------------------------------
    // pin synchronisers, one per port
    // ------------------------------------------------------------
    logic [10:0] pin_raw [2];
    logic [10:0] pin_s1 [2];
    logic [10:0] pin_s2 [2];
    logic clk_s3 [2];

    assign pin_raw[0] = {cam_a_pixel_clock_in, cam_a_line_reference,
                         cam_a_frame_reference, cam_a_data};
    assign pin_raw[1] = {cam_b_pixel_clock_in, cam_b_line_reference,
                         cam_b_frame_reference, cam_b_data};

    for (genvar p = 0; p < 2; p++) begin : g_sync
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                pin_s1[p] <= '0;
                pin_s2[p] <= '0;
                clk_s3[p] <= 1'b0;
            end else begin
                pin_s1[p] <= pin_raw[p];
                pin_s2[p] <= pin_s1[p];
                clk_s3[p] <= pin_s2[p][10];
            end
        end
    end

    // ------------------------------------------------------------
    // registers and bus decode
    // ------------------------------------------------------------
    cam2_signal_s sig;
    cam_config_s cfg;
    logic [7:0] raw_byte;
    logic [31:0] rd_word;
    logic req;
    logic wr;
    logic [15:0] sig_merged;
    logic [15:0] cfg_merged;

    assign req = cyc_i && stb_i;
    // a write lands on the edge where the master sees ack
    assign wr = req && we_i && ack_o;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8],
                   be[0] ? wd[7:0] : old[7:0]};
    endfunction

    assign sig_merged = merge16({10'h000, sig}, dat_i, sel_i);
    assign cfg_merged = merge16({7'h00, cfg}, dat_i, sel_i);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sig <= CAM2_SIGNAL_RESET;
        end else if (wr && adr_i == IDX_CAM2_SIGNAL && !cfg.enable) begin
            // polarity and edge are locked while capture runs [RULE_11]
            sig <= sig_merged[5:0]; // [RULE_01]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CAM_CONFIG_RESET; // [RULE_10]
        end else if (wr && adr_i == IDX_CAM_CONFIG) begin
            // bits 15-9 are not stored and read back as zero [RULE_09]
            cfg <= cfg_merged[8:0];
        end
    end

    logic line_act;
    logic frame_act;
    logic sel_b;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (adr_i)
            IDX_CAM2_SIGNAL: rd_word = {26'h0, sig};
            IDX_CAM_CONFIG: rd_word = {23'h0, cfg}; // [RULE_10]
            IDX_CAM_STATUS: rd_word = {21'h0, sel_b, frame_act, line_act,
                                       raw_byte};
            default: rd_word = 32'h0000_0000; // reserved span [RULE_03]
        endcase
    end

    // every address answers in one cycle; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req && !ack_o;
            if (req && !ack_o) begin
                dat_o <= we_i ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // ------------------------------------------------------------
    // port view, edge detect and references
    // ------------------------------------------------------------
    logic [10:0] cur;
    logic cur_s3;
    logic port_ok;
    logic rise;
    logic fall;
    logic edge_hit;
    logic capture;
    logic href_act;
    logic vref_act;

    assign sel_b = cfg.port == PORT_B;
    assign port_ok = cfg.port == PORT_A || cfg.port == PORT_B; // [RULE_08]
    assign cur = sel_b ? pin_s2[1] : pin_s2[0];
    assign cur_s3 = sel_b ? clk_s3[1] : clk_s3[0];
    assign rise = cur[10] && !cur_s3;
    assign fall = !cur[10] && cur_s3;
    assign edge_hit = (sel_b && sig.clk_falling) ? fall : rise; // [RULE_01]
    assign capture = cfg.enable && port_ok && edge_hit;
    // port A references are taken as active high
    assign href_act = sel_b ? cur[9] == sig.href_high : cur[9]; // [RULE_11]
    assign vref_act = sel_b ? cur[8] == sig.vref_high : cur[8]; // [RULE_11]

    // ------------------------------------------------------------
    // embedded sync code recovery
    // ------------------------------------------------------------
    sync_state_e sync_state;
    logic bt_line;
    logic bt_frame;
    logic is_code;

    assign is_code = cfg.bt656 && sync_state == SYNC_Z2;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_state <= SYNC_IDLE;
        end else if (!cfg.enable || !cfg.bt656) begin
            sync_state <= SYNC_IDLE;
        end else if (capture) begin
            case (sync_state)
                SYNC_IDLE: if (cur[7:0] == SYNC_BYTE_FF) begin
                    sync_state <= SYNC_FF;
                end
                SYNC_FF: sync_state <= (cur[7:0] == SYNC_BYTE_00)
                                       ? SYNC_Z1 : SYNC_IDLE;
                SYNC_Z1: sync_state <= (cur[7:0] == SYNC_BYTE_00)
                                       ? SYNC_Z2 : SYNC_IDLE;
                SYNC_Z2: sync_state <= SYNC_IDLE;
                default: sync_state <= SYNC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bt_line <= 1'b0;
            bt_frame <= 1'b0;
        end else if (capture && is_code) begin
            // end of active video clears the line, start reopens it when V is clear
            bt_line <= !cur[BT_H_BIT] && !cur[BT_V_BIT]; // [RULE_07]
            bt_frame <= !cur[BT_V_BIT]; // [RULE_07]
        end
    end

    assign line_act = cfg.bt656 ? bt_line : href_act; // [RULE_06]
    assign frame_act = cfg.bt656 ? bt_frame : vref_act; // [RULE_06]

    // ------------------------------------------------------------
    // byte phase and pixel output
    // ------------------------------------------------------------
    logic phase;
    logic is_chroma;
    logic take;

    // orders 00/01 start with chroma, 10/11 with luma
    assign is_chroma = sig.byte_order[1] ? phase : !phase;
    // sync preamble bytes never reach the pixel stream
    assign take = capture && line_act
                  && !(cfg.bt656 && (sync_state != SYNC_IDLE
                                     || cur[7:0] == SYNC_BYTE_FF));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 1'b0;
        end else if (!line_act) begin
            phase <= 1'b0;
        end else if (take) begin
            phase <= !phase;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            raw_byte <= 8'h00;
            pixel_out <= '0;
        end else begin
            pixel_out.valid <= take;
            pixel_out.line_valid <= cfg.enable && port_ok && line_act;
            pixel_out.frame_valid <= cfg.enable && port_ok && frame_act;
            if (take) begin
                raw_byte <= cur[7:0];
                // offset binary chroma is moved to straight [RULE_04]
                pixel_out.data <= (is_chroma && cfg.signed_chroma)
                                  ? cur[7:0] ^ CHROMA_FLIP : cur[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // camera clock output
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic clk_tog;
    logic on_a;
    logic on_b;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 8'h00;
            clk_tog <= 1'b0;
        end else if (!cfg.enable) begin
            div_cnt <= 8'h00; // [RULE_12]
            clk_tog <= 1'b0;
        end else if (div_cnt == 8'(CLK_HALF - 1)) begin
            div_cnt <= 8'h00;
            clk_tog <= !clk_tog;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // [RULE_13]
    assign on_a = (cfg.clk_port == CLKP_FOLLOW) ? cfg.port == PORT_A
                  : cfg.clk_port == CLKP_A || cfg.clk_port == CLKP_BOTH;
    assign on_b = (cfg.clk_port == CLKP_FOLLOW) ? cfg.port == PORT_B
                  : cfg.clk_port == CLKP_B || cfg.clk_port == CLKP_BOTH;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            camera_clock_output_a <= 1'b0;
            camera_clock_output_b <= 1'b0;
        end else begin
            // low on the edge after the enable clears [RULE_12]
            camera_clock_output_a <= cfg.enable && on_a && clk_tog;
            camera_clock_output_b <= cfg.enable && on_b && clk_tog;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_rise_capture: assert property ( // [RULE_01]
        (cfg.enable && sel_b && !sig.clk_falling && rise && !cfg.bt656
         && line_act) |=> pixel_out.valid)
        else $error("rising edge byte not captured");
    a_fall_ignored: assert property ( // [RULE_01]
        (cfg.enable && sel_b && sig.clk_falling && rise) |=> !pixel_out.valid)
        else $error("rising edge captured in falling mode");
    a_chroma_flip: assert property ( // [RULE_04]
        (take && is_chroma && cfg.signed_chroma)
        |=> pixel_out.data == (raw_byte ^ CHROMA_FLIP))
        else $error("offset chroma not converted");
    a_luma_kept: assert property ( // [RULE_04]
        (take && !is_chroma) |=> pixel_out.data == raw_byte)
        else $error("luma byte altered");
    a_sep_line: assert property ( // [RULE_06]
        (cfg.enable && !cfg.bt656 && port_ok)
        |=> pixel_out.line_valid == $past(href_act))
        else $error("line valid does not follow reference");
    a_bt656_eav: assert property ( // [RULE_07]
        (capture && is_code && cur[BT_H_BIT] && cfg.enable && cfg.bt656)
        |=> ##1 !pixel_out.line_valid)
        else $error("end code did not close the line");
    a_port_reserved: assert property ( // [RULE_08]
        (cfg.port > PORT_B) |=> !pixel_out.valid && !pixel_out.line_valid)
        else $error("reserved port code captured data");
    a_port_b_data: assert property ( // [RULE_08]
        (take && sel_b) |=> raw_byte == $past(pin_s2[1][7:0]))
        else $error("second port data not selected");
    a_sig_locked: assert property ( // [RULE_11]
        (wr && adr_i == IDX_CAM2_SIGNAL && cfg.enable) |=> $stable(sig))
        else $error("signal setting changed while enabled");
    a_rsvd_zero: assert property ( // [RULE_10]
        (req && !we_i && !ack_o && adr_i == IDX_CAM_CONFIG)
        |=> ack_o && dat_o[15:9] == 7'h00)
        else $error("reserved config bits read nonzero");
    a_clk_off: assert property ( // [RULE_12]
        !cfg.enable |=> !camera_clock_output_a && !camera_clock_output_b)
        else $error("clock output active while disabled");
    a_clk_none: assert property ( // [RULE_13]
        (cfg.clk_port == CLKP_NONE)
        |=> !camera_clock_output_a && !camera_clock_output_b)
        else $error("clock output active with no port");

    c_signed_pixel: cover property (take && is_chroma && cfg.signed_chroma);
    c_bt656_start: cover property (capture && is_code && !cur[BT_H_BIT]);
    c_both_clocks: cover property (camera_clock_output_a
                                   && camera_clock_output_b);
    c_port_b_fall: cover property (take && sel_b && sig.clk_falling);

endmodule

// *** cam_model.sv ***
/*
 * Behavioural camera module for one port: pixel clock, line and frame
 * references and 8-bit data. Assumes the bench loads tx and then calls
 * send_line; the pixel clock stands still (low) outside lines, except for one junk byte clocked before each line.
 */
module cam_model (
    input wire logic line_hi,
    input wire logic frame_hi,
    output logic pclk,
    output logic line_ref,
    output logic frame_ref,
    output logic [7:0] data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx[$];
    logic act = 1'b0;
    // ----------------------------------------------------------------
    // references at the programmed active level
    // ----------------------------------------------------------------
    assign line_ref = act ~^ line_hi;
    assign frame_ref = act ~^ frame_hi;
    initial begin
        pclk = 1'b0;
        data = 8'h5A;
    end
    // data stable 40 ns either side of both edges, so either may latch
    task automatic clock_byte(input logic [7:0] b);
        data = b;
        #40 pclk = 1'b1;
        #80 pclk = 1'b0;
        #40 data = ~b;
    endtask
    // one junk byte outside the line, which the receiver must drop
    task automatic send_line(input bit use_refs);
        // keep pin edges off the bench clock edges
        #5;
        clock_byte(~tx[0]);
        act = use_refs;
        #160;
        foreach (tx[i]) clock_byte(tx[i]);
        #160 act = 1'b0;
        #160;
    endtask
endmodule

// *** tb_top.sv ***
/*
 * Self-checking bench for camera_input_config: Wishbone register access,
 * clock output decode and capture on both camera ports.
 * Assumes cam_model.sv and the design package are compiled first.
 */
module tb_top;
    import camera_input_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:2] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = '0;
    logic [31:0] dat_o;
    logic ack_o;
    logic pclk_a, line_a, frame_a, pclk_b, line_b, frame_b, clk_a, clk_b;
    logic [7:0] data_a, data_b;
    logic b_line_hi = 1'b0;
    logic b_frame_hi = 1'b0;
    pixel_s pix;
    int err_total = 0;
    int compares = 0;
    logic [7:0] cap_q[$];
    logic [7:0] exp_q[$];
    logic [15:0] v;
    int lv_n = 0;
    int fv_n = 0;

    always #10 clk_sys = ~clk_sys;
    // outputs read mid-cycle, where they have settled
    always @(negedge clk_sys) begin
        if (pix.valid === 1'b1) cap_q.push_back(pix.data);
        if (pix.line_valid === 1'b1) lv_n++;
        if (pix.frame_valid === 1'b1) fv_n++;
    end

    camera_input_config #(.CLK_HALF(2)) dut_u (.clk_sys(clk_sys),
        .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .cam_a_pixel_clock_in(pclk_a), .cam_a_line_reference(line_a),
        .cam_a_frame_reference(frame_a), .cam_a_data(data_a),
        .cam_b_pixel_clock_in(pclk_b), .cam_b_line_reference(line_b),
        .cam_b_frame_reference(frame_b), .cam_b_data(data_b),
        .camera_clock_output_a(clk_a), .camera_clock_output_b(clk_b),
        .pixel_out(pix));
    cam_model cam_a (.line_hi(1'b1), .frame_hi(1'b1), .pclk(pclk_a),
        .line_ref(line_a), .frame_ref(frame_a), .data(data_a));
    cam_model cam_b (.line_hi(b_line_hi), .frame_hi(b_frame_hi),
        .pclk(pclk_b), .line_ref(line_b), .frame_ref(frame_b),
        .data(data_b));

    // ----------------------------------------------------------------
    // compares and expectations
    // ----------------------------------------------------------------
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] e);
        compares++;
        if (got !== e) begin
            err_total++;
            $display("ERROR %0t register %h expected %h", $time, got, e);
        end
    endtask
    task automatic chk_pix(input logic [7:0] got, input logic [7:0] e);
        compares++;
        if (got !== e) begin
            err_total++;
            $display("ERROR %0t pixel %h expected %h", $time, got, e);
        end
    endtask
    task automatic chk_cnt(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo,
                hi);
        end
    endtask
    // bits 11-10 always written as zero
    function automatic logic [15:0] cfg(input logic sg, input logic bt,
        input logic [2:0] port, input logic [2:0] cp, input logic en);
        return {7'h00, sg, bt, port, cp, en};
    endfunction
    function automatic logic [1:0] exp_clk(input logic [2:0] cp,
        input logic [2:0] port);
        if (cp == CLKP_FOLLOW)
            return (port == PORT_A) ? 2'h1 : (port == PORT_B) ? 2'h2 : 2'h0;
        return (cp == CLKP_A) ? 2'h1 : (cp == CLKP_B) ? 2'h2 :
            (cp == CLKP_BOTH) ? 2'h3 : 2'h0;
    endfunction
    function automatic logic [7:0] exp_pix(input logic [7:0] b, input int ph,
        input logic [1:0] ord, input logic sg);
        logic chroma;
        chroma = ord[1] ? ph[0] : !ph[0];
        return (sg && chroma) ? b ^ CHROMA_FLIP : b;
    endfunction

    // ----------------------------------------------------------------
    // bus and stimulus tasks
    // ----------------------------------------------------------------
    task automatic wb(input logic [13:0] idx, input logic w,
        input logic [15:0] wd, output logic [15:0] rd);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= idx;
        sel <= 4'h3;
        wdat <= {16'h0000, wd};
        // no cycle count assumed; only the watchdog ends a lost answer
        do begin
            @(posedge clk_sys);
        end while (ack_o !== 1'b1);
        rd = dat_o[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [13:0] idx, input logic [15:0] d);
        logic [15:0] r;
        wb(idx, 1'b1, d, r);
    endtask
    task automatic rd_chk(input logic [13:0] idx, input logic [15:0] e);
        logic [15:0] r;
        wb(idx, 1'b0, 16'h0000, r);
        chk_reg(r, e);
    endtask
    task automatic run_line(input bit bt, input logic [1:0] ord,
        input logic sg, input bit on_b, input bit none);
        logic [7:0] tx[$];
        logic [7:0] b;
        int span;
        tx.delete();
        if (bt) tx = {SYNC_BYTE_FF, SYNC_BYTE_00, SYNC_BYTE_00, 8'h80};
        exp_q.delete();
        cap_q.delete();
        lv_n = 0;
        fv_n = 0;
        for (int i = 0; i < 12; i++) begin
            b = 8'($urandom_range(254, 1));
            tx.push_back(b);
            if (!none) exp_q.push_back(exp_pix(b, i, ord, sg));
        end
        if (bt) tx = {tx, SYNC_BYTE_FF, SYNC_BYTE_00, SYNC_BYTE_00, 8'h90};
        if (on_b) begin
            cam_b.tx = tx;
            cam_b.send_line(!bt);
        end else begin
            cam_a.tx = tx;
            cam_a.send_line(!bt);
        end
        repeat (8) @(posedge clk_sys);
        chk_cnt(cap_q.size(), exp_q.size(), exp_q.size());
        foreach (exp_q[i]) begin
            if (i < cap_q.size()) chk_pix(cap_q[i], exp_q[i]);
        end
        // line spans 14 pixel clocks by reference, 16 between codes
        span = none ? 0 : bt ? 128 : 112;
        chk_cnt(lv_n, span - !none, span + !none);
        if (!bt) chk_cnt(fv_n, span - !none, span + !none);
        $display("test line port %0d embedded %0d done", on_b, bt);
    endtask
    task automatic clk_test();
        int na, nb;
        logic pa, pb;
        logic [1:0] e;
        for (int cp = 0; cp < 8; cp++) for (int p = 0; p < 3; p++) begin
            wr(IDX_CAM_CONFIG, cfg(1'b0, 1'b0, 3'(p), 3'(cp), 1'b1));
            e = exp_clk(3'(cp), 3'(p));
            na = 0;
            nb = 0;
            repeat (32) begin
                pa = clk_a;
                pb = clk_b;
                @(posedge clk_sys);
                #1;
                if (clk_a === 1'b1 && pa === 1'b0) na++;
                if (clk_b === 1'b1 && pb === 1'b0) nb++;
            end
            chk_cnt(na, e[0] ? 7 : 0, e[0] ? 9 : 0);
            chk_cnt(nb, e[1] ? 7 : 0, e[1] ? 9 : 0);
        end
        wr(IDX_CAM_CONFIG, 16'h0000);
        @(posedge clk_sys);
        #1;
        chk_reg({14'h0000, clk_b, clk_a}, 16'h0000);
        $display("test clock outputs done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #200_000;
        err_total++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        v = 16'($urandom(2));
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(IDX_CAM2_SIGNAL, 16'h0000);
        rd_chk(IDX_CAM_CONFIG, 16'h0000);
        wr(IDX_CAM_CONFIG, 16'hF200);
        rd_chk(IDX_CAM_CONFIG, 16'h0000);
        // the reserved span is only ever read
        rd_chk(IDX_RSVD_FIRST, 16'h0000);
        rd_chk(IDX_RSVD_LAST, 16'h0000);
        wr(14'h0100, 16'hFFFF);
        rd_chk(14'h0100, 16'h0000);
        v = 16'($urandom) & 16'h003F;
        wr(IDX_CAM2_SIGNAL, v);
        rd_chk(IDX_CAM2_SIGNAL, v);
        wr(IDX_CAM_CONFIG, cfg(1'b0, 1'b0, PORT_B, CLKP_NONE, 1'b1));
        wr(IDX_CAM2_SIGNAL, (~v & 16'h003E) | (v & 16'h0001));
        rd_chk(IDX_CAM2_SIGNAL, v);
        wr(IDX_CAM_CONFIG, 16'h0000);
        $display("test registers done");
        clk_test();
        for (int k = 0; k < 4; k++) begin
            v = 16'($urandom) & 16'h001F;
            v[0] = k[0];
            wr(IDX_CAM2_SIGNAL, v);
            b_line_hi <= v[2];
            b_frame_hi <= v[1];
            wr(IDX_CAM_CONFIG, cfg(k[1], 1'b0, PORT_B, CLKP_FOLLOW, 1'b1));
            run_line(1'b0, v[4:3], k[1], 1'b1, 1'b0);
            wr(IDX_CAM_CONFIG, 16'h0000);
        end
        wr(IDX_CAM2_SIGNAL, 16'h0010);
        wr(IDX_CAM_CONFIG, cfg(1'b1, 1'b0, PORT_A, CLKP_A, 1'b1));
        run_line(1'b0, 2'h2, 1'b1, 1'b0, 1'b0);
        wr(IDX_CAM_CONFIG, cfg(1'b0, 1'b0, 3'h2, CLKP_A, 1'b1));
        run_line(1'b0, 2'h2, 1'b0, 1'b0, 1'b1);
        wr(IDX_CAM_CONFIG, cfg(1'b0, 1'b1, PORT_A, CLKP_A, 1'b1));
        run_line(1'b1, 2'h2, 1'b0, 1'b0, 1'b0);
        print_verdict();
    end
endmodule
